// ### opl_nvm_if.sv
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps
// Behaviour
// - Rx-tune trigger copies the calibration word into the rx tune output.
// - Channel select bit picks the channel 5 or channel 9 calibration word.
// - Regulator trigger copies nonvolatile word 0x4 into the regulator tune output.
// - Bias trigger copies nonvolatile word 0xA into the bias control output.
// - Parameter-set trigger loads the set chosen by the select field.
// - Select code 00 is long, 10 is short; code 01 is reserved.
// - Programming-done flag sets when the word has been programmed.
// - Status reports whether the programming supply is good enough.
// - A read places the addressed nonvolatile word into the read-data register.
// - After reset the word at 0x60 appears in the special read-data register.
// - Address register bits 10 to 0 select the location accessed.
// - Configuration bit 1 starts a nonvolatile read.
// - Configuration bit 0 enables manual read and program sequencing.
module opl_nvm_if #(
	parameter logic [opl_pkg::OPL_CNT_W-1:0] ACCESS_CYCLES = opl_pkg::OPL_ACCESS_DEF,
	parameter logic [opl_pkg::OPL_CNT_W-1:0] PROG_CYCLES   = opl_pkg::OPL_PROG_DEF,
	parameter int                            NVM_DEPTH     = 2048
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        vpp_ok,
	output logic      [31:0] rx_tune,
	output logic      [31:0] regulator_tune,
	output logic      [31:0] bias_ctrl,
	output logic      [1:0]  param_set,
	output logic             irq
);
	import opl_pkg::*;

	logic [31:0]            nvm_mem [NVM_DEPTH];
	logic [31:0]            nvm_write_data;
	logic [OPL_AW-1:0]      nvm_addr;
	logic [15:0]            nvm_config;
	logic                   program_done_flag;
	logic [31:0]            nvm_read_data;
	logic [31:0]            special_word_read_data;
	logic [INT_W-1:0]       int_status;
	logic [INT_W-1:0]       int_mask;
	opl_state_e             state;
	opl_op_e                op;
	logic [OPL_AW-1:0]      op_addr;
	logic [1:0]             op_param;
	logic [OPL_CNT_W-1:0]   cnt;
	logic                   d_wr;
	logic                   rd_pend;
	logic [7:0]             d_addr;
	logic                   a_go;
	logic                   wr_en;
	logic                   cfg_wr;
	logic                   op_done;
	logic [31:0]            nvm_word;
	logic [31:0]            rd_mux;
	logic                   want_prog;
	logic                   want_read;
	logic                   want_rx;
	logic                   want_reg;
	logic                   want_bias;
	logic                   want_ps;
	logic                   start_req;
	logic                   start_ok;
	logic                   refuse;
	opl_op_e                next_op;
	logic [OPL_AW-1:0]      next_addr;
	logic [INT_W-1:0]       int_set;

	// AHB-Lite slave: writes take no wait state, reads take one so hrdata is a flop
	assign a_go = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign wr_en = d_wr;
	assign cfg_wr = wr_en && d_addr == OFF_CFG;
	assign hreadyout = !rd_pend;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			d_wr <= 1'b0;
			rd_pend <= 1'b0;
			d_addr <= 8'h00;
		end else begin
			d_wr <= a_go && hwrite;
			rd_pend <= a_go && !hwrite;
			if (a_go) begin
				d_addr <= {haddr[7:2], 2'b00};
			end
		end
	end

	always_comb begin
		if (d_addr == OFF_WDATA) begin
			rd_mux = nvm_write_data;
		end else if (d_addr == OFF_ADDR) begin
			rd_mux = {21'h00000, nvm_addr};
		end else if (d_addr == OFF_CFG) begin
			rd_mux = {16'h0000, nvm_config};
		end else if (d_addr == OFF_STAT) begin
			rd_mux = {30'h0000000, vpp_ok, program_done_flag};
		end else if (d_addr == OFF_RDATA) begin
			rd_mux = nvm_read_data;
		end else if (d_addr == OFF_SRDATA) begin
			rd_mux = special_word_read_data;
		end else if (d_addr == OFF_INT_STAT) begin
			rd_mux = {28'h0000000, int_status};
		end else if (d_addr == OFF_INT_MASK) begin
			rd_mux = {28'h0000000, int_mask};
		end else begin
			rd_mux = ZERO32;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= ZERO32;
		end else if (rd_pend) begin
			hrdata <= rd_mux;
		end
	end

	// Trigger decode; only one operation runs, lower-priority triggers are refused
	assign want_prog = cfg_wr && hwdata[CFG_WRITE] && hwdata[CFG_MAN] && vpp_ok;
	assign want_read = cfg_wr && hwdata[CFG_READ] && hwdata[CFG_MAN];
	assign want_rx = cfg_wr && hwdata[CFG_RXK];
	assign want_reg = cfg_wr && hwdata[CFG_REGK];
	assign want_bias = cfg_wr && hwdata[CFG_BIASK];
	assign want_ps = cfg_wr && hwdata[CFG_PSK]
		&& hwdata[CFG_PSEL_HI:CFG_PSEL_LO] != PSET_RSVD;
	assign start_req = want_prog || want_read || want_rx || want_reg || want_bias || want_ps;
	assign start_ok = start_req && state == ST_IDLE;
	assign refuse = cfg_wr && ((hwdata[CFG_WRITE] && !want_prog)
		|| (hwdata[CFG_READ] && !want_read)
		|| (hwdata[CFG_PSK] && !want_ps)
		|| (start_req && state != ST_IDLE)
		|| (want_prog && (want_read || want_rx || want_reg || want_bias || want_ps))
		|| (want_read && (want_rx || want_reg || want_bias || want_ps))
		|| (want_rx && (want_reg || want_bias || want_ps))
		|| (want_reg && (want_bias || want_ps))
		|| (want_bias && want_ps));

	always_comb begin
		next_op = OP_PARAM;
		next_addr = nvm_addr;
		if (want_prog) begin
			next_op = OP_PROG;
		end else if (want_read) begin
			next_op = OP_READ;
		end else if (want_rx) begin
			next_op = OP_RXTUNE;
			next_addr = hwdata[CFG_RXSEL] ? NVA_RX9 : NVA_RX5;
		end else if (want_reg) begin
			next_op = OP_REGTUNE;
			next_addr = NVA_REG;
		end else if (want_bias) begin
			next_op = OP_BIAS;
			next_addr = NVA_BIAS;
		end
	end

	assign op_done = state == ST_BUSY && cnt == OPL_CNT_ONE;
	assign nvm_word = nvm_mem[op_addr];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_POWERUP;
			op <= OP_SPECIAL;
			op_addr <= NVA_SPECIAL;
			op_param <= PSET_SHORT;
			cnt <= ACCESS_CYCLES;
		end else begin
			case (state)
				ST_POWERUP: begin
					if (cnt == OPL_CNT_ONE) begin
						state <= ST_IDLE;
					end else begin
						cnt <= cnt - OPL_CNT_ONE;
					end
				end
				ST_IDLE: begin
					if (start_ok) begin
						state <= ST_BUSY;
						op <= next_op;
						op_addr <= next_addr;
						op_param <= hwdata[CFG_PSEL_HI:CFG_PSEL_LO];
						cnt <= want_prog ? PROG_CYCLES : ACCESS_CYCLES;
					end
				end
				ST_BUSY: begin
					if (op_done) begin
						state <= ST_IDLE;
					end else begin
						cnt <= cnt - OPL_CNT_ONE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Array is cleared by reset; this models a blank part, not retention across resets
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NVM_DEPTH; i++) begin
				nvm_mem[i] <= ZERO32;
			end
		end else if (op_done && op == OP_PROG) begin
			nvm_mem[op_addr] <= nvm_word | nvm_write_data;
		end
	end

	// Software registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nvm_write_data <= ZERO32;
			nvm_addr <= '0;
			nvm_config <= 16'h0000;
			int_mask <= '0;
		end else if (wr_en) begin
			if (d_addr == OFF_WDATA) begin
				nvm_write_data <= hwdata;
			end else if (d_addr == OFF_ADDR) begin
				nvm_addr <= hwdata[OPL_AW-1:0];
			end else if (d_addr == OFF_CFG) begin
				// Trigger bits are single shot and never stored
				nvm_config <= {2'b00, hwdata[CFG_RXSEL], hwdata[CFG_PSEL_HI:CFG_PSEL_LO],
					7'h00, hwdata[CFG_WMODE], 2'b00, hwdata[CFG_MAN]};
			end else if (d_addr == OFF_INT_MASK) begin
				int_mask <= hwdata[INT_W-1:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			program_done_flag <= 1'b0;
		end else if (op_done && op == OP_PROG) begin
			program_done_flag <= 1'b1;
		end else if (wr_en && d_addr == OFF_STAT && hwdata[STAT_DONE]) begin
			program_done_flag <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nvm_read_data <= ZERO32;
		end else if (op_done && op == OP_READ) begin
			nvm_read_data <= nvm_word;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			special_word_read_data <= ZERO32;
		end else if (state == ST_POWERUP && cnt == OPL_CNT_ONE) begin
			special_word_read_data <= nvm_word;
		end else if (wr_en && d_addr == OFF_SRDATA) begin
			special_word_read_data <= hwdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_tune <= ZERO32;
			regulator_tune <= ZERO32;
			bias_ctrl <= ZERO32;
			param_set <= PSET_SHORT;
		end else if (op_done) begin
			case (op)
				OP_RXTUNE: rx_tune <= nvm_word;
				OP_REGTUNE: regulator_tune <= nvm_word;
				OP_BIAS: bias_ctrl <= nvm_word;
				OP_PARAM: param_set <= op_param;
				default: param_set <= param_set;
			endcase
		end
	end

	// Interrupts: sticky, write one to clear, a new event wins over the clear
	always_comb begin
		int_set = '0;
		int_set[INT_PROG] = op_done && op == OP_PROG;
		int_set[INT_READ] = op_done && op == OP_READ;
		int_set[INT_LOAD] = op_done && op != OP_PROG && op != OP_READ;
		int_set[INT_REFUSE] = refuse;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_status <= '0;
		end else if (wr_en && d_addr == OFF_INT_STAT) begin
			int_status <= (int_status & ~hwdata[INT_W-1:0]) | int_set;
		end else begin
			int_status <= int_status | int_set;
		end
	end

	assign irq = |(int_status & int_mask);

	a_rx_copy: assert property (@(posedge hclk) disable iff (!hresetn)
		op_done && op == OP_RXTUNE |=> rx_tune == $past(nvm_word))
		else $error("rx tune not loaded");
	a_rx_select: assert property (@(posedge hclk) disable iff (!hresetn)
		start_ok && next_op == OP_RXTUNE
		|=> op_addr == ($past(hwdata[CFG_RXSEL]) ? NVA_RX9 : NVA_RX5))
		else $error("rx tune channel address wrong");
	a_reg_addr: assert property (@(posedge hclk) disable iff (!hresetn)
		state == ST_BUSY && op == OP_REGTUNE |-> op_addr == NVA_REG)
		else $error("regulator address wrong");
	a_bias_copy: assert property (@(posedge hclk) disable iff (!hresetn)
		op_done && op == OP_BIAS |=> bias_ctrl == $past(nvm_word) && state == ST_IDLE)
		else $error("bias not loaded");
	a_param_load: assert property (@(posedge hclk) disable iff (!hresetn)
		op_done && op == OP_PARAM |=> param_set == $past(op_param) && param_set != PSET_RSVD)
		else $error("parameter set not loaded");
	a_prog_done: assert property (@(posedge hclk) disable iff (!hresetn)
		op_done && op == OP_PROG |=> program_done_flag && int_status[INT_PROG])
		else $error("program done not flagged");
	a_read_data: assert property (@(posedge hclk) disable iff (!hresetn)
		op_done && op == OP_READ |=> nvm_read_data == $past(nvm_word))
		else $error("read data not captured");
	a_powerup_word: assert property (@(posedge hclk) disable iff (!hresetn)
		state == ST_POWERUP && cnt == OPL_CNT_ONE
		|=> state == ST_IDLE && special_word_read_data == $past(nvm_word))
		else $error("special word not captured");
	a_manual_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		start_ok && (next_op == OP_READ || next_op == OP_PROG) |-> hwdata[CFG_MAN])
		else $error("manual op without manual control");
	a_busy_refuse: assert property (@(posedge hclk) disable iff (!hresetn)
		state == ST_BUSY && start_req && !op_done |=> $stable(op) && int_status[INT_REFUSE])
		else $error("busy trigger not refused");
	a_busy_len: assert property (@(posedge hclk) disable iff (!hresetn)
		state == ST_IDLE && start_ok && !want_prog |=> state == ST_BUSY [*4])
		else $error("operation shorter than access time");

	c_prog: cover property (@(posedge hclk) disable iff (!hresetn)
		op_done && op == OP_PROG);
	c_read: cover property (@(posedge hclk) disable iff (!hresetn)
		op_done && op == OP_READ);
	c_param: cover property (@(posedge hclk) disable iff (!hresetn)
		op_done && op == OP_PARAM && op_param == PSET_LONG);
	c_refuse: cover property (@(posedge hclk) disable iff (!hresetn)
		refuse && state == ST_BUSY);
endmodule

// ### opl_pkg.sv
package opl_pkg;
	localparam int OPL_AW = 11;
	localparam int OPL_CNT_W = 8;
	localparam logic [OPL_CNT_W-1:0] OPL_ACCESS_DEF = 8'h04;
	localparam logic [OPL_CNT_W-1:0] OPL_PROG_DEF = 8'h10;
	localparam logic [OPL_CNT_W-1:0] OPL_CNT_ONE = 8'h01;
	localparam logic [7:0] OFF_WDATA = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_CFG = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0C;
	localparam logic [7:0] OFF_RDATA = 8'h10;
	localparam logic [7:0] OFF_SRDATA = 8'h14;
	localparam logic [7:0] OFF_INT_STAT = 8'h18;
	localparam logic [7:0] OFF_INT_MASK = 8'h1C;
	localparam int CFG_MAN = 0;
	localparam int CFG_READ = 1;
	localparam int CFG_WRITE = 2;
	localparam int CFG_WMODE = 3;
	localparam int CFG_RXK = 6;
	localparam int CFG_REGK = 7;
	localparam int CFG_BIASK = 8;
	localparam int CFG_PSK = 10;
	localparam int CFG_PSEL_LO = 11;
	localparam int CFG_PSEL_HI = 12;
	localparam int CFG_RXSEL = 13;
	localparam int STAT_DONE = 0;
	localparam int STAT_VPP = 1;
	localparam int INT_PROG = 0;
	localparam int INT_READ = 1;
	localparam int INT_LOAD = 2;
	localparam int INT_REFUSE = 3;
	localparam int INT_W = 4;
	localparam logic [OPL_AW-1:0] NVA_REG = 11'h004;
	localparam logic [OPL_AW-1:0] NVA_BIAS = 11'h00A;
	localparam logic [OPL_AW-1:0] NVA_RX5 = 11'h020;
	localparam logic [OPL_AW-1:0] NVA_RX9 = 11'h034;
	localparam logic [OPL_AW-1:0] NVA_SPECIAL = 11'h060;
	localparam logic [1:0] PSET_LONG = 2'b00;
	localparam logic [1:0] PSET_RSVD = 2'b01;
	localparam logic [1:0] PSET_SHORT = 2'b10;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ = 2'b11;
	typedef enum logic [1:0] {ST_POWERUP, ST_IDLE, ST_BUSY} opl_state_e;
	typedef enum logic [2:0] {
		OP_SPECIAL, OP_READ, OP_PROG, OP_RXTUNE, OP_REGTUNE, OP_BIAS, OP_PARAM
	} opl_op_e;
endpackage

// ### otp_param_load_interface_test.sv
`timescale 1ns/100ps
`define CHK(g, e) \
	begin \
		tests_run++; \
		if ((g) !== (e)) begin \
			$display("wrong value at %0t: got %h expected %h", $time, g, e); \
			error_cnt++; \
		end \
	end
module otp_param_load_interface_test;
	import opl_pkg::*;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire logic   hready;
	logic [31:0] hrdata;
	logic        hresp;
	logic        vpp_ok;
	logic [31:0] rx_tune;
	logic [31:0] regulator_tune;
	logic [31:0] bias_ctrl;
	logic [1:0]  param_set;
	logic        irq;
	logic [31:0] mem [int];
	int          error_cnt = 0;
	int          tests_run = 0;
	int          seed = 32'h02d8f613;
	int          cyc = 0;
	logic [31:0] s;
	logic [31:0] v;
	logic        q;
	logic [10:0] ra;
	logic [31:0] reg_exp;

	opl_nvm_if #(
		.ACCESS_CYCLES (8'h04),
		.PROG_CYCLES   (8'h02),
		.NVM_DEPTH     (2048)
	) i_dut (
		.hclk           (hclk),
		.hresetn        (hresetn),
		.hsel           (hsel),
		.haddr          (haddr),
		.htrans         (htrans),
		.hwrite         (hwrite),
		.hsize          (hsize),
		.hwdata         (hwdata),
		.hready         (hready),
		.hrdata         (hrdata),
		.hreadyout      (hready),
		.hresp          (hresp),
		.vpp_ok         (vpp_ok),
		.rx_tune        (rx_tune),
		.regulator_tune (regulator_tune),
		.bias_ctrl      (bias_ctrl),
		.param_set      (param_set),
		.irq            (irq)
	);

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	task automatic results();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// A hang in a bus wait ends here rather than running forever
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end

	function automatic logic [31:0] nv(input logic [10:0] a);
		return mem.exists(a) ? mem[a] : ZERO32;
	endfunction

	// Entered and left just after a rising edge
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
			output logic [31:0] rd);
		haddr <= {24'h000000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hsel <= 1'b1;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(a, 1'b1, d, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus(a, 1'b0, ZERO32, d);
	endtask

	// Poll the event flag with a bound, note irq, then clear every event
	task automatic op(input logic [31:0] cfg, input int b, output logic [31:0] st,
			output logic iq);
		int n;
		wr(OFF_CFG, cfg);
		n = 0;
		st = ZERO32;
		while (st[b] !== 1'b1 && n < 40) begin
			rd(OFF_INT_STAT, st);
			n++;
		end
		`CHK(st[b], 1'b1)
		iq = irq;
		wr(OFF_INT_STAT, 32'h0000_000F);
	endtask

	task automatic prog(input logic [10:0] a, input logic [31:0] d);
		wr(OFF_ADDR, {21'h00000, a});
		wr(OFF_WDATA, d);
		op(32'h0000_0005, INT_PROG, s, q);
		mem[a] = nv(a) | d;
		`CHK(s[INT_PROG], 1'b1)
		rd(OFF_STAT, s);
		`CHK(s[1:0], 2'b11)
		wr(OFF_STAT, 32'h0000_0001);
		rd(OFF_STAT, s);
		`CHK(s[0], 1'b0)
	endtask

	task automatic rdnv(input logic [10:0] a);
		wr(OFF_ADDR, {21'h00000, a});
		op(32'h0000_0003, INT_READ, s, q);
		rd(OFF_RDATA, v);
		`CHK(v, nv(a))
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = ZERO32;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = ZERO32;
		vpp_ok = 1'b1;
		repeat (12) @(posedge hclk);
		`CHK(param_set, PSET_SHORT)
		`CHK(rx_tune, ZERO32)
		hresetn <= 1'b1;
		repeat (8) @(posedge hclk);
		rd(OFF_SRDATA, v);
		`CHK(v, ZERO32)
		rd(8'h40, v);
		`CHK(v, ZERO32)
		wr(OFF_INT_MASK, 32'h0000_000F);
		ra = 11'h100 | 11'($random(seed) & 8'hFF);
		prog(NVA_RX5, $random(seed));
		prog(NVA_RX9, $random(seed));
		prog(NVA_REG, $random(seed));
		prog(NVA_BIAS, $random(seed));
		prog(ra, $random(seed));
		prog(ra, $random(seed));
		foreach (mem[a]) rdnv(11'(a));
		for (int sel = 0; sel < 2; sel++) begin
			op(32'h0000_0040 | (sel << CFG_RXSEL), INT_LOAD, s, q);
			`CHK(rx_tune, nv(sel ? NVA_RX9 : NVA_RX5))
			`CHK(q, 1'b1)
		end
		op(32'h0000_0080, INT_LOAD, s, q);
		`CHK(regulator_tune, nv(NVA_REG))
		reg_exp = nv(NVA_REG);
		op(32'h0000_0100, INT_LOAD, s, q);
		`CHK(bias_ctrl, nv(NVA_BIAS))
		op(32'h0000_0400 | (PSET_LONG << CFG_PSEL_LO), INT_LOAD, s, q);
		`CHK(param_set, PSET_LONG)
		op(32'h0000_0400 | (PSET_SHORT << CFG_PSEL_LO), INT_LOAD, s, q);
		`CHK(param_set, PSET_SHORT)
		op(32'h0000_0400 | (PSET_RSVD << CFG_PSEL_LO), INT_REFUSE, s, q);
		`CHK(param_set, PSET_SHORT)
		wr(OFF_CFG, 32'h0000_3008);
		rd(OFF_CFG, v);
		`CHK(v, 32'h0000_3008)
		op(32'h0000_0002, INT_REFUSE, s, q);
		`CHK(s[INT_REFUSE], 1'b1)
		vpp_ok <= 1'b0;
		rd(OFF_STAT, s);
		`CHK(s[STAT_VPP], 1'b0)
		wr(OFF_ADDR, {21'h00000, ra});
		wr(OFF_WDATA, 32'hFFFF_FFFF);
		op(32'h0000_0005, INT_REFUSE, s, q);
		`CHK(s[INT_PROG], 1'b0)
		vpp_ok <= 1'b1;
		rdnv(ra);
		// New bits at the regulator word, so a wrongly accepted reload would show
		prog(NVA_REG, ~nv(NVA_REG));
		// Second trigger lands while the first load still runs
		wr(OFF_CFG, 32'h0000_0040);
		op(32'h0000_0080, INT_REFUSE, s, q);
		`CHK(s[INT_REFUSE], 1'b1)
		repeat (8) @(posedge hclk);
		wr(OFF_INT_STAT, 32'h0000_000F);
		wr(OFF_INT_MASK, ZERO32);
		op(32'h0000_0100, INT_LOAD, s, q);
		`CHK(s[INT_LOAD], 1'b1)
		`CHK(q, 1'b0)
		`CHK(regulator_tune, reg_exp)
		`CHK(hresp, 1'b0)
		results();
	end
endmodule
